// ==== design/adcpo_delay_line.sv ====
// Delay line that moves one code plus its over-range bit per convert edge.
// Assumes advance is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ns
`default_nettype none
module adcpo_delay_line #(
    parameter int DEPTH = 4,
    parameter int W = 12
) (
    input wire logic clock_in,
    input wire logic srst_in,
    adcpo_stage_if.line stage_if
);
    import adcpo_pkg::*;

    logic [W:0] stage_reg [DEPTH];
    logic [W:0] stage_next [DEPTH];

    // ==========================================================
    // Stages
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            stage_next[i] = stage_reg[i];
            if (stage_if.flush) begin
                stage_next[i] = '0;
            end else if (stage_if.advance) begin
                stage_next[i] = (i == 0) ? stage_if.din : stage_reg[(i == 0) ? 0 : i - 1];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (srst_in) begin
                stage_reg[i] <= '0;
            end else begin
                stage_reg[i] <= stage_next[i];
            end
        end
    end

    assign stage_if.dout = stage_reg[DEPTH-1];
endmodule
`default_nettype wire

// ==== design/adcpo_pkg.sv ====
// Constants shared by the converter output control block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package adcpo_pkg;
    // ==========================================================
    // Data path
    localparam int WORD_W = 12;
    localparam int LATENCY = 5;
    localparam int PIPE_DEPTH = LATENCY - 1;
    localparam logic [2:0] FILL_RST = 3'h0;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS = 4'h8;
    localparam logic [3:0] SAMPLE_OFS = 4'hC;
    // ==========================================================
    // Control fields
    localparam int CTRL_TWOS_BIT = 0;
    localparam int CTRL_FLOAT_BIT = 1;
    localparam int CTRL_PD_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // ==========================================================
    // Status and mask fields
    localparam int EV_WORD_BIT = 0;
    localparam int EV_OVR_BIT = 1;
    localparam logic [1:0] EV_RST = 2'h0;
    // ==========================================================
    // Sample register fields
    localparam int SMP_OVR_BIT = 12;
    localparam int SMP_VALID_BIT = 13;
    localparam int SMP_PD_BIT = 14;
    localparam int SMP_FLOAT_BIT = 15;
    localparam logic [11:0] WORD_RST = 12'h000;
endpackage

// ==== design/adcpo_stage_if.sv ====
// Carrier between the control logic and the sample delay line.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface adcpo_stage_if #(
    parameter int W = 12
);
    logic advance;
    logic flush;
    logic [W:0] din;
    logic [W:0] dout;
    modport line (input advance, input flush, input din, output dout);
    modport ctrl (output advance, output flush, output din, input dout);
endinterface
`default_nettype wire

// ==== design/adcpo_top.sv ====
// Output control of a 12-bit pipelined converter: coding, float, power-down, valid and over-range.
// Assumes pins arrive asynchronously and software uses Avalon-MM with waitrequest.
`timescale 1ns/1ns
`default_nettype none
module adcpo_top (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic convert_clk_in,
    input wire logic [adcpo_pkg::WORD_W-1:0] core_code_in,
    input wire logic core_overrange_in,
    input wire logic twos_complement_sel_in,
    input wire logic output_float_in,
    input wire logic powerdown_pin_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [adcpo_pkg::WORD_W-1:0] sample_data_out,
    output logic sample_data_oe_out,
    output logic overrange_flag_out,
    output logic sample_valid_strobe_out,
    output logic powered_down_out,
    output logic irq_out
);
    import adcpo_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // Code and over-range pass the same two stages as the convert clock so they stay aligned with its edge.
    localparam int SYNC_W = WORD_W + 5;
    logic [SYNC_W-1:0] sync1_reg, sync2_reg;
    logic cclk_prev_reg;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            cclk_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {convert_clk_in, core_overrange_in, core_code_in, twos_complement_sel_in,
                          output_float_in, powerdown_pin_in};
            sync2_reg <= sync1_reg;
            cclk_prev_reg <= sync2_reg[SYNC_W-1];
        end
    end

    logic cclk_s, ovr_s, twos_pin_s, float_pin_s, pd_pin_s;
    logic [WORD_W-1:0] code_s;
    assign cclk_s = sync2_reg[SYNC_W-1];
    assign ovr_s = sync2_reg[SYNC_W-2];
    assign code_s = sync2_reg[SYNC_W-3:3];
    assign twos_pin_s = sync2_reg[2];
    assign float_pin_s = sync2_reg[1];
    assign pd_pin_s = sync2_reg[0];

    // ==========================================================
    // Register bus state
    logic [2:0] ctrl_reg, ctrl_next;
    logic [1:0] status_reg, status_next;
    logic [1:0] mask_reg, mask_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;

    logic twos_sel, float_sel, pd_sel;
    assign twos_sel = twos_pin_s | ctrl_reg[CTRL_TWOS_BIT];
    assign float_sel = float_pin_s | ctrl_reg[CTRL_FLOAT_BIT];
    assign pd_sel = pd_pin_s | ctrl_reg[CTRL_PD_BIT];

    // ==========================================================
    // Conversion state
    logic [WORD_W-1:0] word_reg, word_next;
    logic ovr_reg, ovr_next;
    logic valid_reg, valid_next;
    logic oe_reg, oe_next;
    logic pd_reg, pd_next;
    logic [2:0] fill_reg, fill_next;
    logic ev_word, ev_ovr;

    adcpo_stage_if #(.W(WORD_W)) stage_if ();

    // The line holds one full latency of samples, so the word leaving it is five convert edges old.
    adcpo_delay_line #(
        .DEPTH(LATENCY),
        .W(WORD_W)
    ) u_line (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .stage_if(stage_if)
    );

    logic advance;
    assign advance = cclk_s & ~cclk_prev_reg & ~pd_sel;
    assign stage_if.advance = advance;
    assign stage_if.flush = pd_sel;
    assign stage_if.din = {ovr_s, code_s};

    always_comb begin
        word_next = word_reg;
        ovr_next = ovr_reg;
        valid_next = valid_reg;
        fill_next = fill_reg;
        ev_word = 1'b0;
        ev_ovr = 1'b0;
        pd_next = pd_sel;
        oe_next = ~float_sel;
        if (pd_sel) begin
            // Power-down discards samples in flight so no stale word is flagged valid on wake-up.
            fill_next = FILL_RST;
            valid_next = 1'b0;
            ovr_next = 1'b0;
        end else if (advance) begin
            if (fill_reg == 3'(LATENCY)) begin
                // Offset binary becomes two's complement by inverting the sign bit.
                word_next = stage_if.dout[WORD_W-1:0] ^ {twos_sel, {(WORD_W-1){1'b0}}};
                ovr_next = stage_if.dout[WORD_W];
                valid_next = 1'b1;
                ev_word = 1'b1;
                ev_ovr = stage_if.dout[WORD_W];
            end else begin
                fill_next = fill_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            word_reg <= WORD_RST;
            ovr_reg <= 1'b0;
            valid_reg <= 1'b0;
            fill_reg <= FILL_RST;
            oe_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            ovr_reg <= ovr_next;
            valid_reg <= valid_next;
            fill_reg <= fill_next;
            oe_reg <= oe_next;
            pd_reg <= pd_next;
        end
    end

    // ==========================================================
    // Avalon-MM slave
    // Every access waits exactly one cycle; the access completes on the cycle waitrequest is low.
    logic req, done;
    assign req = avs_read_in | avs_write_in;
    assign done = req & ~wait_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        rdata_next = rdata_reg;
        wait_next = 1'b1;
        if (req && wait_reg) begin
            wait_next = 1'b0;
            rdata_next = 32'h0000_0000;
            if (avs_read_in) begin
                case (avs_address_in)
                    CTRL_OFS: rdata_next[2:0] = ctrl_reg;
                    STATUS_OFS: rdata_next[1:0] = status_reg;
                    MASK_OFS: rdata_next[1:0] = mask_reg;
                    SAMPLE_OFS: begin
                        rdata_next[WORD_W-1:0] = word_reg;
                        rdata_next[SMP_OVR_BIT] = ovr_reg;
                        rdata_next[SMP_VALID_BIT] = valid_reg;
                        rdata_next[SMP_PD_BIT] = pd_reg;
                        rdata_next[SMP_FLOAT_BIT] = ~oe_reg;
                    end
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
        if (done && avs_write_in && avs_byteenable_in[0]) begin
            if (avs_address_in == CTRL_OFS) begin
                ctrl_next = avs_writedata_in[2:0];
            end
            if (avs_address_in == MASK_OFS) begin
                mask_next = avs_writedata_in[1:0];
            end
        end
        if (done && avs_read_in && avs_address_in == STATUS_OFS) begin
            // Only the bits handed to software are cleared, so an event after the snapshot stays pending.
            status_next = status_reg & ~rdata_reg[1:0];
        end
        // New events are applied after the read clear so an event in the clearing cycle survives.
        if (ev_word) begin
            status_next[EV_WORD_BIT] = 1'b1;
        end
        if (ev_ovr) begin
            status_next[EV_OVR_BIT] = 1'b1;
        end
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= EV_RST;
            status_reg <= EV_RST;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
            irq_reg <= irq_next;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign sample_data_out = word_reg;
    assign sample_data_oe_out = oe_reg;
    assign overrange_flag_out = ovr_reg;
    assign sample_valid_strobe_out = valid_reg;
    assign powered_down_out = pd_reg;
    assign irq_out = irq_reg;
endmodule
`default_nettype wire

// ==== tb/adc_parallel_output_control_tb_top.sv ====
// Self-checking bench for the converter output control block.
// Assumes the capture model paces samples and the checker is bound to the top.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module adc_parallel_output_control_tb_top;
    import adcpo_pkg::*;
    logic clk = 1'b0, srst = 1'b1, sel = 1'b0, flt = 1'b0, pd = 1'b0, run = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, q, rdata;
    logic [11:0] word, cc;
    logic [12:0] last;
    logic cv, co, wrq, oe, overrange_flag, vld, pdo, irq;
    logic [3:0] map [5] = '{CTRL_OFS, STATUS_OFS, MASK_OFS, SAMPLE_OFS, 4'h2};
    int err_count = 0, cmp_count = 0, cyc = 0, base = 0;
    initial forever #5 clk = ~clk;
    adcpo_cap_model u_cap (.clock_in(clk), .run_in(run), .conv_out(cv), .code_out(cc), .ovr_out(co));
    adcpo_top u_dut (.clock_in(clk), .srst_in(srst), .convert_clk_in(cv), .core_code_in(cc),
        .core_overrange_in(co), .twos_complement_sel_in(sel), .output_float_in(flt), .powerdown_pin_in(pd),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wrq),
        .sample_data_out(word), .sample_data_oe_out(oe), .overrange_flag_out(overrange_flag),
        .sample_valid_strobe_out(vld), .powered_down_out(pdo), .irq_out(irq));
    // ==========================================================
    // Tasks
    task automatic print_verdict();
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Offset binary turns into two's complement by flipping the sign bit.
    function automatic logic [11:0] exp_word(input logic [12:0] s, input logic tw);
        return s[11:0] ^ {tw, 11'h000};
    endfunction
    // Entered just after a clock edge; leaves one idle cycle so no strobe is set twice in a step.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wrq !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k == 50) err_count++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stream(input int cnt, input logic tw);
        int i;
        for (i = 0; i < cnt; i++) begin
            run <= 1'b1;
            @(posedge cv);
            repeat (6) @(posedge clk);
            last = u_cap.hist[u_cap.n - LATENCY];
            if (u_cap.n - base > LATENCY) begin
                `CHK("word", exp_word(last, tw), word)
                `CHK("ovr", last[12], overrange_flag)
            end
            `CHK("valid", u_cap.n - base > LATENCY, vld)
        end
        run <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        int i;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        for (i = 0; i < 5; i++) begin
            bus(1'b0, map[i], 32'h0);
            `CHK("reset", 32'h0, q)
        end
        bus(1'b1, MASK_OFS, 32'h1);
        stream(8, 1'b0);
        `CHK("irq", 1'b1, irq)
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("status", 1'b1, q[0])
        `CHK("status ovr", u_cap.hist[1][12] | u_cap.hist[2][12] | u_cap.hist[3][12], q[1])
        repeat (2) @(posedge clk);
        `CHK("irq clr", 1'b0, irq)
        sel <= 1'b1;
        bus(1'b1, MASK_OFS, 32'h0);
        stream(8, 1'b1);
        `CHK("irq mask", 1'b0, irq)
        sel <= 1'b0;
        bus(1'b1, CTRL_OFS, 32'h1);
        stream(6, 1'b1);
        bus(1'b0, SAMPLE_OFS, 32'h0);
        `CHK("sample", {3'h1, last[12], exp_word(last, 1'b1)}, q[15:0])
        flt <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("oe pin", 1'b0, oe)
        flt <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK("oe on", 1'b1, oe)
        bus(1'b1, CTRL_OFS, 32'h3);
        repeat (2) @(posedge clk);
        `CHK("oe ctrl", 1'b0, oe)
        bus(1'b0, SAMPLE_OFS, 32'h0);
        `CHK("smp float", 1'b1, q[SMP_FLOAT_BIT])
        bus(1'b1, CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("oe back", 1'b1, oe)
        pd <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("pd", 3'b100, {pdo, vld, overrange_flag})
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        repeat (12) @(posedge clk);
        `CHK("pd word", exp_word(last, 1'b1), word)
        pd <= 1'b0;
        bus(1'b1, CTRL_OFS, 32'h4);
        repeat (4) @(posedge clk);
        `CHK("pd ctrl", 3'b100, {pdo, vld, overrange_flag})
        bus(1'b0, SAMPLE_OFS, 32'h0);
        `CHK("smp pd", 4'h4, q[15:12])
        bus(1'b1, CTRL_OFS, 32'h0);
        repeat (4) @(posedge clk);
        base = u_cap.n;
        stream(7, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== tb/adcpo_cap_model.sv ====
// Capture-side model: makes the convert clock and the core code that each edge samples.
// Assumes the bench raises run_in to ask for samples; the convert clock rests low otherwise.
`timescale 1ns/1ns
`default_nettype none
module adcpo_cap_model (
    input wire logic clock_in,
    input wire logic run_in,
    output logic conv_out,
    output logic [11:0] code_out,
    output logic ovr_out
);
    int seed = 95;
    int n = 0;
    int ph = 0;
    logic [12:0] hist [0:1023];
    initial begin
        conv_out = 1'b0;
        code_out = 12'h000;
        ovr_out = 1'b0;
    end
    // ==========================================================
    // Convert clock
    // A period ends before stopping, so no level is ever cut shorter than four cycles.
    always @(posedge clock_in) begin
        if (run_in || ph != 0) begin
            ph <= (ph + 1) % 8;
            if (ph == 0) begin
                conv_out <= 1'b1;
                hist[n + 1] = {ovr_out, code_out};
                n <= n + 1;
            end
            if (ph == 4) begin
                conv_out <= 1'b0;
                code_out <= 12'($random(seed));
                ovr_out <= ($random(seed) & 3) == 0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/adcpo_chk.sv ====
// Port checker for the converter output control block.
// Assumes it is bound to adcpo_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module adcpo_chk (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic convert_clk_in,
    input wire logic output_float_in,
    input wire logic powerdown_pin_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic [11:0] sample_data_out,
    input wire logic sample_data_oe_out,
    input wire logic overrange_flag_out,
    input wire logic sample_valid_strobe_out,
    input wire logic powered_down_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // ==========================================================
    // Properties
    property p_float_off;
        output_float_in [*4] |-> !sample_data_oe_out;
    endproperty
    a_float_off: assert property (p_float_off) else $error("data driven while float high");
    property p_pd_state;
        powerdown_pin_in [*4] |-> powered_down_out && !sample_valid_strobe_out && !overrange_flag_out;
    endproperty
    a_pd_state: assert property (p_pd_state) else $error("not powered down");
    property p_pd_hold;
        powered_down_out [*4] |-> $stable(sample_data_out);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("word moved in power down");
    property p_valid_live;
        sample_valid_strobe_out |-> !powered_down_out;
    endproperty
    a_valid_live: assert property (p_valid_live) else $error("valid in power down");
    property p_ovr_valid;
        overrange_flag_out |-> sample_valid_strobe_out;
    endproperty
    a_ovr_valid: assert property (p_ovr_valid) else $error("flag without word");
    // A new word follows a convert rising edge that has passed the two sync stages.
    property p_word_edge;
        $changed(sample_data_out) |-> $past(convert_clk_in, 2) || $past(convert_clk_in, 3);
    endproperty
    a_word_edge: assert property (p_word_edge) else $error("word changed without edge");
    property p_bus_answer;
        $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    property p_bus_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_bus_one: assert property (p_bus_one) else $error("wait low too long");
endmodule
bind adcpo_top adcpo_chk u_chk (.*);
`default_nettype wire
